// ### logic/srw_pkg.sv
// Shared timing constants and state encoding for the supervisory reset block
`default_nettype none
package srw_pkg;
  // Clock period of the internal timebase, in ns
  localparam int unsigned CLK_PERIOD_NS = 10;
  // Reset hold period, nominal figure in ms (range 140 to 280)
  localparam longint unsigned RESET_HOLD_PERIOD_MS = 210;
  localparam longint unsigned RESET_HOLD_CYCLES =
    RESET_HOLD_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  // Watchdog period, nominal figure in ms (range 1120 to 2400)
  localparam longint unsigned WATCHDOG_PERIOD_MS = 1760;
  localparam longint unsigned WATCHDOG_CYCLES =
    WATCHDOG_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  // Supply-low qualification time in us
  localparam int unsigned SUPPLY_QUAL_US = 40;
  localparam int unsigned SUPPLY_QUAL_CYCLES = SUPPLY_QUAL_US * 1000 / CLK_PERIOD_NS;
  // Manual reset debounce in ns: above the 100 ns noise pulse, below the 1000 ns minimum
  localparam int unsigned MANUAL_DEBOUNCE_NS = 500;
  localparam int unsigned MANUAL_DEBOUNCE_CYCLES = MANUAL_DEBOUNCE_NS / CLK_PERIOD_NS;
  // Narrowest service pulse in ns; one clock resolves it
  localparam int unsigned WATCHDOG_PULSE_MIN_NS = 50;
  localparam int unsigned COUNT_W = 32;
  localparam int unsigned QUAL_W = 13;
  localparam logic [QUAL_W-1:0] QUAL_ZERO = 13'h0000;
  localparam logic [QUAL_W-1:0] QUAL_ONE = 13'h0001;
  localparam logic [COUNT_W-1:0] COUNT_ZERO = 32'h0000_0000;
  localparam logic [COUNT_W-1:0] COUNT_ONE = 32'h0000_0001;
  typedef enum logic [1:0] {
    SRW_RUN = 2'b00,
    SRW_ACTIVE = 2'b01,
    SRW_HOLD = 2'b10
  } srw_state_t;
endpackage
`default_nettype wire

// ### logic/srw_supervisor.sv
// Supervisory reset generator: supply-low, manual reset and watchdog causes
`timescale 1ns/10ps
`default_nettype none

// Shared by supply and manual causes: same qualify-then-flag behaviour
// Counts consecutive active samples and flags once the count is reached
module srw_qualify #(
  parameter logic [srw_pkg::QUAL_W-1:0] LIMIT = 13'h0001
) (
  input wire logic clock,
  input wire logic clear,
  input wire logic active,
  output logic qualified_r
);
  logic [srw_pkg::QUAL_W-1:0] cnt_r;

  // A single inactive sample restarts the count, so only steady levels act
  always_ff @(posedge clock)
  begin
    if (clear || !active)
    begin
      cnt_r <= srw_pkg::QUAL_ZERO;
      qualified_r <= 1'b0;
    end
    else if (cnt_r < LIMIT - srw_pkg::QUAL_ONE)
      cnt_r <= cnt_r + srw_pkg::QUAL_ONE;
    else
      qualified_r <= 1'b1;
  end
endmodule

module srw_supervisor #(
  parameter bit WATCHDOG_EN = 1'b1,
  parameter bit MANUAL_EN = 1'b1,
  // Counters are 32 bits: enough for the nominal periods at 100 MHz
  parameter logic [31:0] HOLD_CYCLES = 32'(srw_pkg::RESET_HOLD_CYCLES),
  parameter logic [31:0] WDOG_CYCLES = 32'(srw_pkg::WATCHDOG_CYCLES)
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic supply_low,
  input wire logic manual_reset_n,
  input wire logic watchdog_service_in,
  input wire logic watchdog_service_float,
  output logic reset_n_r,
  output logic reset_r
);
  // Qualification limits in clock cycles
  localparam logic [12:0] SUPPLY_QUAL = 13'(srw_pkg::SUPPLY_QUAL_CYCLES);
  localparam logic [12:0] MANUAL_QUAL = 13'(srw_pkg::MANUAL_DEBOUNCE_CYCLES);

  logic supply_q_r;
  logic manual_q_r;
  logic manual_clear;
  logic service_prev_r;
  logic service_edge;
  logic [31:0] wdog_cnt_r;
  logic wdog_fire;
  logic [31:0] hold_cnt_r;
  logic hold_done;
  srw_pkg::srw_state_t state_r;
  srw_pkg::srw_state_t state_nxt;
  logic cause;
  logic assert_nxt;

  // Supply-low must persist before acting, so short dips are ignored
  srw_qualify #(
    .LIMIT(SUPPLY_QUAL)
  ) u_supply_qual (
    .clock(clock),
    .clear(sys_rst),
    .active(supply_low),
    .qualified_r(supply_q_r)
  );

  // An absent manual input is treated as released
  assign manual_clear = sys_rst || !MANUAL_EN;

  // Manual debounce; the 500 ns qualification also sets the manual-to-reset delay
  srw_qualify #(
    .LIMIT(MANUAL_QUAL)
  ) u_manual_qual (
    .clock(clock),
    .clear(manual_clear),
    .active(!manual_reset_n),
    .qualified_r(manual_q_r)
  );

  // Previous service level for edge detection
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      service_prev_r <= 1'b0;
    else
      service_prev_r <= watchdog_service_in;
  end

  // Either polarity counts, and one sample is enough for a 50 ns pulse
  assign service_edge = watchdog_service_in != service_prev_r;

  // Watchdog counter; held at full count while firing so it cannot wrap
  always_ff @(posedge clock)
  begin
    if (sys_rst || !WATCHDOG_EN)
      wdog_cnt_r <= srw_pkg::COUNT_ZERO;
    else if (!reset_n_r)
      wdog_cnt_r <= srw_pkg::COUNT_ZERO;
    else if (watchdog_service_float)
      wdog_cnt_r <= srw_pkg::COUNT_ZERO;
    else if (service_edge)
      wdog_cnt_r <= srw_pkg::COUNT_ZERO;
    else if (!wdog_fire)
      wdog_cnt_r <= wdog_cnt_r + srw_pkg::COUNT_ONE;
  end

  // Timeout needs an enabled, driven, quiet input and a full count
  always_comb
  begin
    wdog_fire = 1'b0;
    if (WATCHDOG_EN && reset_n_r && !watchdog_service_float && !service_edge)
    begin
      if (wdog_cnt_r >= WDOG_CYCLES - srw_pkg::COUNT_ONE)
        wdog_fire = 1'b1;
    end
  end

  // Level causes; the watchdog acts only through its one-shot timeout
  assign cause = supply_q_r || manual_q_r;

  assign hold_done = hold_cnt_r >= HOLD_CYCLES - srw_pkg::COUNT_ONE;

  // Level causes keep reset in ACTIVE; a timeout only starts a hold
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      srw_pkg::SRW_RUN:
      begin
        if (cause)
          state_nxt = srw_pkg::SRW_ACTIVE;
        else if (wdog_fire)
          state_nxt = srw_pkg::SRW_HOLD;
      end
      srw_pkg::SRW_ACTIVE:
      begin
        if (!cause)
          state_nxt = srw_pkg::SRW_HOLD;
      end
      srw_pkg::SRW_HOLD:
      begin
        if (cause)
          state_nxt = srw_pkg::SRW_ACTIVE;
        else if (hold_done)
          state_nxt = srw_pkg::SRW_RUN;
      end
      // An illegal code falls back to a full hold rather than releasing
      default:
        state_nxt = srw_pkg::SRW_HOLD;
    endcase
  end

  // Power-up behaves as a cause clearing: one full hold period first
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      state_r <= srw_pkg::SRW_HOLD;
    else
      state_r <= state_nxt;
  end

  // Counts only while the hold state persists; any cause restarts it
  always_ff @(posedge clock)
  begin
    if (sys_rst || state_r != srw_pkg::SRW_HOLD || state_nxt != srw_pkg::SRW_HOLD)
      hold_cnt_r <= srw_pkg::COUNT_ZERO;
    else
      hold_cnt_r <= hold_cnt_r + srw_pkg::COUNT_ONE;
  end

  // Reset is asserted in every state except run
  assign assert_nxt = (state_nxt != srw_pkg::SRW_RUN);

  // Both outputs come from the same next value, so they never disagree
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      reset_n_r <= 1'b0;
    else
      reset_n_r <= !assert_nxt;
  end

  // Separate flop keeps the active-high pin free of any gate after the register
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      reset_r <= 1'b1;
    else
      reset_r <= assert_nxt;
  end
endmodule
`default_nettype wire

// ### sim/srw_chk_sva.sv
// Port checks for the supervisory reset block
`timescale 1ns/10ps
`default_nettype none
module srw_chk #(parameter logic [31:0] HOLD_CYCLES = 32'h0000_00C8, WDOG_CYCLES = 32'h0000_012C) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic supply_low,
  input wire logic manual_reset_n,
  input wire logic watchdog_service_in,
  input wire logic watchdog_service_float,
  input wire logic reset_n_r,
  input wire logic reset_r
);
  logic [31:0] sl_r, mr_r, hd_r, wd_r;
  logic svc_r;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  // Raw causes clear the hold count, so glitches while in hold would upset it
  always_ff @(posedge clock)
  begin
    svc_r <= watchdog_service_in;
    sl_r <= (sys_rst || !supply_low) ? 32'h0 : sl_r + 32'h1;
    mr_r <= (sys_rst || manual_reset_n) ? 32'h0 : mr_r + 32'h1;
    hd_r <= (sys_rst || reset_n_r || supply_low || !manual_reset_n) ? 32'h0 : hd_r + 32'h1;
    wd_r <= (sys_rst || !reset_n_r || watchdog_service_float || watchdog_service_in != svc_r)
      ? 32'h0 : wd_r + 32'h1;
  end
  chk_out_inverse: assert property (reset_r == !reset_n_r) else $error("not inverse");
  chk_supply_asserts: assert property (sl_r >= 32'h0FA2 |-> !reset_n_r) else $error("supply");
  chk_manual_asserts: assert property (mr_r >= 32'h33 |-> !reset_n_r) else $error("manual");
  chk_hold_min: assert property ($rose(reset_n_r) |-> hd_r >= HOLD_CYCLES) else $error("short");
  chk_hold_max: assert property (!reset_n_r |-> hd_r <= HOLD_CYCLES + 32'h4) else $error("long");
  chk_wdog_timeout: assert property (wd_r >= WDOG_CYCLES + 32'h3 |-> !reset_n_r) else $error("wd");
  chk_fall_cause: assert property ($fell(reset_n_r) |-> sl_r >= 32'h0FA0 || mr_r >= 32'h31
    || wd_r >= WDOG_CYCLES - 32'h3) else $error("no cause");
  chk_release_clear: assert property ($rose(reset_n_r) |-> sl_r < 32'h0FA0 && mr_r < 32'h32)
    else $error("cause pending");
endmodule
bind srw_supervisor srw_chk #(.HOLD_CYCLES(HOLD_CYCLES), .WDOG_CYCLES(WDOG_CYCLES)) u_srw_chk (
  .clock(clock), .sys_rst(sys_rst), .supply_low(supply_low), .manual_reset_n(manual_reset_n),
  .watchdog_service_in(watchdog_service_in), .watchdog_service_float(watchdog_service_float),
  .reset_n_r(reset_n_r), .reset_r(reset_r));
`default_nettype wire

// ### sim/srw_cpu_model.sv
// Processor model that services the watchdog with short pulses
`timescale 1ns/10ps
`default_nettype none
module srw_cpu_model #(parameter int PERIOD = 100, parameter int HIGH = 5) (
  input wire logic clock,
  input wire logic svc_en,
  output logic svc = 1'b0
);
  int cnt = 0;
  // Same-polarity edges can be spaced beyond the watchdog period, so both edges must clear it
  always @(posedge clock)
  begin
    cnt <= (cnt + 1) % PERIOD;
    svc <= #1 svc_en && cnt < HIGH;
  end
endmodule
`default_nettype wire

// ### sim/tb_top.sv
// Self-checking bench for the supervisory reset block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clock = 1'b0, sys_rst = 1'b1, supply_low = 1'b0, manual_reset_n = 1'b1;
  logic float_in = 1'b0, en = 1'b0, svc, reset_n_r, reset_r;
  logic [31:0] seed = 32'h0000_000A;
  int bad_count = 0, n_tests = 0, cyc = 0;
  always #5 clock = ~clock;
  always @(posedge clock)
    if (++cyc > 20000)
      end_of_test(1);
  srw_cpu_model #(.PERIOD(320), .HIGH(160)) u_srw_cpu_model (.clock(clock), .svc_en(en),
    .svc(svc));
  srw_supervisor #(.HOLD_CYCLES(32'h0000_00C8), .WDOG_CYCLES(32'h0000_012C)) u_srw_supervisor (
    .clock(clock), .sys_rst(sys_rst), .supply_low(supply_low), .manual_reset_n(manual_reset_n),
    .watchdog_service_in(svc), .watchdog_service_float(float_in), .reset_n_r(reset_n_r),
    .reset_r(reset_r));
  function automatic int rnd(input int m);
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return int'(seed % 32'(m));
  endfunction
  task automatic chk(input int n, input logic exp);
    repeat (n) @(posedge clock);
    #1;
    n_tests++;
    if (reset_n_r !== exp || reset_r !== !exp)
    begin
      bad_count++;
      $display("unexpected at %0t: reset_n_r %b reset_r %b", $time, reset_n_r, reset_r);
    end
    $display("test %0d done at %0t", n_tests, $time);
  endtask
  task automatic end_of_test(input int hang);
    bad_count += hang;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    chk(12, 1'b0);
    sys_rst = 1'b0;
    en = 1'b1;
    chk(195, 1'b0);
    chk(10, 1'b1);
    manual_reset_n = 1'b0;
    chk(5 + rnd(40), 1'b1);
    manual_reset_n = 1'b1;
    chk(60, 1'b1);
    manual_reset_n = 1'b0;
    chk(45, 1'b1);
    chk(10, 1'b0);
    manual_reset_n = 1'b1;
    chk(195, 1'b0);
    chk(10, 1'b1);
    supply_low = 1'b1;
    chk(100 + rnd(3000), 1'b1);
    supply_low = 1'b0;
    chk(10, 1'b1);
    supply_low = 1'b1;
    chk(3995, 1'b1);
    chk(510, 1'b0);
    supply_low = 1'b0;
    chk(195, 1'b0);
    chk(10, 1'b1);
    en = 1'b0;
    float_in = 1'b1;
    chk(900, 1'b1);
    float_in = 1'b0;
    chk(290, 1'b1);
    chk(15, 1'b0);
    en = 1'b1;
    chk(1205, 1'b1);
    sys_rst = 1'b1;
    chk(2, 1'b0);
    end_of_test(0);
  end
endmodule
`default_nettype wire
